// ===== hw/cyclic_sense_wake_timers.v
/*
 * Two periodic timers (A and B) with one 16-bit configuration register,
 * driving high-side switches for cyclic sensing, a cyclic wake pulse and
 * a timer-synchronous wake input filter.
 * Assumes the register port is driven by the SPI decoder in the same clock
 * domain, and that mode signals come from the device mode controller.
 */
// What this block does
// - Timer B on-time field bits 15:13
// - Code 000 stops low, 110 stops high
// - Reserved on-time code 111 acts as 110
// - Timer B period field bits 11:9
// - Timer A on-time field bits 6:4
// - Timer A period field bits 2:0
// - Wake source field bits 8:7 selects timer
// - Reserved bits 12, 3 ignore writes, read zero
// - Register clears on reset and Restart entry
// - Timer starts once running on-time written
// - Restart switch clear also clears its timer
// - Other failures keep timer settings
// - Cyclic wake and sensing run together
// - Switch codes 0010/0011 follow timer A/B
// - Cyclic wake input filtered 16 us at on-end
`timescale 1ns/1ps
`include "cyclic_timers_defines.vh"

module cyclic_sense_wake_timers (
    // Clock and reset
    input wire sys_clk_in,
    input wire rstn_in,
    // Configuration register port
    input wire cfg_wr_in,
    input wire [15:0] cfg_wdata_in,
    output wire [15:0] cfg_rdata_out,
    // Device mode events
    input wire soft_reset_in,
    input wire restart_entry_in,
    input wire restart_mode_in,
    input wire [3:0] hs_clear_in,
    // High-side switch configuration, four 4-bit fields
    input wire [15:0] hs_config_in,
    // Wake input
    input wire [2:0] wake_input_filter_select_in,
    input wire wake_pin_in,
    // Outputs
    output wire timer_a_out,
    output wire timer_b_out,
    output reg [3:0] high_side_switch_output_out,
    output reg cyclic_wake_out,
    output reg wake_sample_valid_out,
    output reg wake_level_out
);

    function is_running;
        input [2:0] code;
        begin
            is_running = (code >= `ON_100US) && (code <= `ON_20MS);
        end
    endfunction

    // Stopped codes other than 000 hold the output high
    function hold_high;
        input [2:0] code;
        begin
            hold_high = (code != `ON_OFF_LOW);
        end
    endfunction

    function [`DUR_W-1:0] on_dur;
        input [2:0] code;
        begin
            case (code)
                `ON_100US: on_dur = `T_100US;
                `ON_300US: on_dur = `T_300US;
                `ON_1MS: on_dur = `T_1MS;
                `ON_10MS: on_dur = `T_10MS;
                `ON_20MS: on_dur = `T_20MS;
                default: on_dur = `DUR_ZERO;
            endcase
        end
    endfunction

    function [`DUR_W-1:0] per_dur;
        input [2:0] code;
        begin
            case (code)
                `PER_10MS: per_dur = `T_10MS;
                `PER_20MS: per_dur = `T_20MS;
                `PER_50MS: per_dur = `T_50MS;
                `PER_100MS: per_dur = `T_100MS;
                `PER_200MS: per_dur = `T_200MS;
                `PER_500MS: per_dur = `T_500MS;
                `PER_1S: per_dur = `T_1S;
                default: per_dur = `T_2S;
            endcase
        end
    endfunction

    // Other sources of the switch lie outside this block and read low
    function sw_level;
        input [`HS_CFG_W-1:0] cfg;
        input lvl_a;
        input lvl_b;
        begin
            case (cfg)
                `HS_ON: sw_level = 1'b1;
                `HS_TIMER_A: sw_level = lvl_a;
                `HS_TIMER_B: sw_level = lvl_b;
                default: sw_level = 1'b0;
            endcase
        end
    endfunction

    reg [15:0] periodic_timer_config_r;
    reg [15:0] periodic_timer_config_nxt;
    reg [`TICK_CNT_W-1:0] tick_cnt_r;
    reg us_tick_r;
    reg clr_a;
    reg clr_b;
    reg [`FILT_CNT_W-1:0] stable_cnt_r;
    reg prev_pin_r;
    wire [1:0] tmr_out_w;
    wire [1:0] tmr_start_w;
    wire [1:0] tmr_end_w;
    wire [1:0] wake_src;
    wire [3:0] high_side_switch_output_nxt;
    integer i;

    assign cfg_rdata_out = periodic_timer_config_r;
    assign wake_src = periodic_timer_config_r[`WAKE_SRC_MSB:`WAKE_SRC_LSB];
    assign timer_a_out = tmr_out_w[0];
    assign timer_b_out = tmr_out_w[1];

    // Microsecond tick enable
    always @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tick_cnt_r <= {`TICK_CNT_W{1'b0}};
            us_tick_r <= 1'b0;
        end else if (tick_cnt_r == `TICK_LAST) begin
            tick_cnt_r <= {`TICK_CNT_W{1'b0}};
            us_tick_r <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 1'b1;
            us_tick_r <= 1'b0;
        end
    end

    // Switch clear in Restart Mode wipes the timer that switch follows
    always @* begin
        clr_a = 1'b0;
        clr_b = 1'b0;
        for (i = 0; i < 4; i = i + 1) begin
            if (restart_mode_in && hs_clear_in[i]) begin
                if (hs_config_in[i*`HS_CFG_W +: `HS_CFG_W] == `HS_TIMER_A) begin
                    clr_a = 1'b1;
                end
                if (hs_config_in[i*`HS_CFG_W +: `HS_CFG_W] == `HS_TIMER_B) begin
                    clr_b = 1'b1;
                end
            end
        end
    end

    // Hardware clears win over a write in the same cycle
    always @* begin
        periodic_timer_config_nxt = periodic_timer_config_r;
        if (cfg_wr_in) begin
            periodic_timer_config_nxt = cfg_wdata_in & `CFG_WRITE_MASK;
        end
        if (clr_a) begin
            periodic_timer_config_nxt = periodic_timer_config_nxt & ~`TA_FIELDS_MASK;
        end
        if (clr_b) begin
            periodic_timer_config_nxt = periodic_timer_config_nxt & ~`TB_FIELDS_MASK;
        end
        if (soft_reset_in || restart_entry_in) begin
            periodic_timer_config_nxt = `CFG_RESET;
        end
    end

    // Only these events touch the settings; other failures leave them
    always @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            periodic_timer_config_r <= `CFG_RESET;
        end else begin
            periodic_timer_config_r <= periodic_timer_config_nxt;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : tmr
            wire [2:0] on_code;
            wire [2:0] per_code;
            wire [`DUR_W-1:0] on_len;
            wire [`DUR_W-1:0] per_len;
            wire run;
            reg [`DUR_W-1:0] cnt_r;
            reg out_r;
            reg start_r;
            reg end_r;

            if (g == 0) begin : sel_a
                assign on_code = periodic_timer_config_r[`TA_ON_MSB:`TA_ON_LSB];
                assign per_code = periodic_timer_config_r[`TA_PER_MSB:`TA_PER_LSB];
            end else begin : sel_b
                assign on_code = periodic_timer_config_r[`TB_ON_MSB:`TB_ON_LSB];
                assign per_code = periodic_timer_config_r[`TB_PER_MSB:`TB_PER_LSB];
            end

            assign on_len = on_dur(on_code);
            assign per_len = per_dur(per_code);
            assign run = is_running(on_code);

            // Count restarts from zero whenever the timer is stopped
            always @(posedge sys_clk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    cnt_r <= `DUR_ZERO;
                    out_r <= 1'b0;
                    start_r <= 1'b0;
                    end_r <= 1'b0;
                end else if (!run) begin
                    cnt_r <= `DUR_ZERO;
                    out_r <= hold_high(on_code);
                    start_r <= 1'b0;
                    end_r <= 1'b0;
                end else if (us_tick_r) begin
                    // Period shortened mid-count wraps at once, not after overflow
                    cnt_r <= (cnt_r >= per_len - `DUR_ONE) ? `DUR_ZERO : cnt_r + `DUR_ONE;
                    out_r <= (cnt_r < on_len);
                    start_r <= (cnt_r == `DUR_ZERO);
                    // Coincides with the falling edge, so the full on-time has passed
                    end_r <= (cnt_r == on_len);
                end else begin
                    start_r <= 1'b0;
                    end_r <= 1'b0;
                end
            end

            assign tmr_out_w[g] = out_r;
            assign tmr_start_w[g] = start_r;
            assign tmr_end_w[g] = end_r;
        end

        for (g = 0; g < 4; g = g + 1) begin : hs
            wire [`HS_CFG_W-1:0] cfg;
            assign cfg = hs_config_in[g*`HS_CFG_W +: `HS_CFG_W];
            assign high_side_switch_output_nxt[g] = sw_level(cfg, tmr_out_w[0], tmr_out_w[1]);
        end
    endgenerate

    // One process for all four switch bits keeps a single driver
    always @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            high_side_switch_output_out <= 4'h0;
        end else begin
            high_side_switch_output_out <= high_side_switch_output_nxt;
        end
    end

    // Wake pulse is independent of switch use, so both run together
    always @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cyclic_wake_out <= 1'b0;
        end else begin
            cyclic_wake_out <= ((wake_src == `WAKE_SRC_A) && tmr_start_w[0]) ||
                               ((wake_src == `WAKE_SRC_B) && tmr_start_w[1]);
        end
    end

    // Stability counter of the wake input, one step per microsecond
    always @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            stable_cnt_r <= {`FILT_CNT_W{1'b0}};
            prev_pin_r <= 1'b0;
        end else if (us_tick_r) begin
            prev_pin_r <= wake_pin_in;
            if (wake_pin_in != prev_pin_r) begin
                stable_cnt_r <= {`FILT_CNT_W{1'b0}};
            end else if (stable_cnt_r < `FILT_US) begin
                stable_cnt_r <= stable_cnt_r + 1'b1;
            end
        end
    end

    // Sample at on-time end; level only updates if stable for 16 us
    always @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wake_sample_valid_out <= 1'b0;
            wake_level_out <= 1'b0;
        end else begin
            wake_sample_valid_out <= 1'b0;
            if (((wake_input_filter_select_in == `FILT_TIMER_A) && tmr_end_w[0]) ||
                ((wake_input_filter_select_in == `FILT_TIMER_B) && tmr_end_w[1])) begin
                wake_sample_valid_out <= 1'b1;
                if (stable_cnt_r >= `FILT_US) begin
                    wake_level_out <= wake_pin_in;
                end
            end
        end
    end

endmodule // cyclic_sense_wake_timers

// ===== hw/cyclic_timers_defines.vh
/*
 * Constants for the cyclic sense / cyclic wake timer block: register
 * field positions, codes, durations and the microsecond tick divider.
 * Assumes a 25 MHz system clock; included by the timer module only.
 */
`ifndef CYCLIC_TIMERS_DEFINES_VH
`define CYCLIC_TIMERS_DEFINES_VH

// Clock and tick
`define CLK_PERIOD_NS 40
`define TICK_PERIOD_NS 1000
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define TICK_CNT_W 5
`define TICK_LAST 5'h18

// Register layout
`define CFG_RESET 16'h0000
`define CFG_WRITE_MASK 16'hEFF7
`define TB_ON_MSB 15
`define TB_ON_LSB 13
`define TB_PER_MSB 11
`define TB_PER_LSB 9
`define WAKE_SRC_MSB 8
`define WAKE_SRC_LSB 7
`define TA_ON_MSB 6
`define TA_ON_LSB 4
`define TA_PER_MSB 2
`define TA_PER_LSB 0
`define TB_FIELDS_MASK 16'hEE00
`define TA_FIELDS_MASK 16'h0077

// On-time codes
`define ON_OFF_LOW 3'h0
`define ON_100US 3'h1
`define ON_300US 3'h2
`define ON_1MS 3'h3
`define ON_10MS 3'h4
`define ON_20MS 3'h5

// Period codes
`define PER_10MS 3'h0
`define PER_20MS 3'h1
`define PER_50MS 3'h2
`define PER_100MS 3'h3
`define PER_200MS 3'h4
`define PER_500MS 3'h5
`define PER_1S 3'h6

// Durations in microseconds (one tick each)
`define DUR_W 21
`define T_100US 21'h000064
`define T_300US 21'h00012C
`define T_1MS 21'h0003E8
`define T_10MS 21'h002710
`define T_20MS 21'h004E20
`define T_50MS 21'h00C350
`define T_100MS 21'h0186A0
`define T_200MS 21'h030D40
`define T_500MS 21'h07A120
`define T_1S 21'h0F4240
`define T_2S 21'h1E8480
`define DUR_ONE 21'h000001
`define DUR_ZERO 21'h000000

// Wake source and filter select codes
`define WAKE_SRC_A 2'h1
`define WAKE_SRC_B 2'h2
`define FILT_TIMER_A 3'h2
`define FILT_TIMER_B 3'h3
`define FILT_US 5'h10
`define FILT_CNT_W 5

// High-side switch configuration codes
`define HS_CFG_W 4
`define HS_OFF 4'h0
`define HS_ON 4'h1
`define HS_TIMER_A 4'h2
`define HS_TIMER_B 4'h3

`endif

// ===== dv/cyclic_timers_checker.sv
/* Assertions on the timer block ports.
   Assumes the 25 MHz clock and active-low async reset of the block. */
`timescale 1ns/1ps
module cyclic_timers_checker (
    // Clock and reset
    input wire sys_clk_in,
    input wire rstn_in,
    // Register and mode inputs
    input wire cfg_wr_in,
    input wire [15:0] cfg_wdata_in,
    input wire soft_reset_in,
    input wire restart_entry_in,
    input wire restart_mode_in,
    input wire [3:0] hs_clear_in,
    input wire [15:0] hs_config_in,
    // Observed outputs
    input wire [15:0] cfg_rdata_out,
    input wire timer_a_out,
    input wire [3:0] high_side_switch_output_out,
    input wire cyclic_wake_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);
    chk_rsvd_zero: assert property (cfg_rdata_out[12] == 1'b0 && cfg_rdata_out[3] == 1'b0)
        else $error("reserved bit set");
    chk_write_echo: assert property (cfg_wr_in && !soft_reset_in && !restart_entry_in && !restart_mode_in
        |=> cfg_rdata_out == ($past(cfg_wdata_in) & 16'hEFF7)) else $error("write not shown");
    chk_soft_clear: assert property (soft_reset_in || restart_entry_in |=> cfg_rdata_out == 16'h0000)
        else $error("register not cleared");
    chk_off_low: assert property (cfg_rdata_out[6:4] == 3'h0 && $stable(cfg_rdata_out[6:4]) |-> !timer_a_out)
        else $error("stopped timer not low");
    chk_off_high: assert property (cfg_rdata_out[6:5] == 2'h3 && $stable(cfg_rdata_out[6:4]) |-> timer_a_out)
        else $error("stopped timer not high");
    chk_hs_follow: assert property ($past(hs_config_in[3:0]) == 4'h2
        |-> high_side_switch_output_out[0] == $past(timer_a_out)) else $error("switch not following");
    chk_wake_pulse: assert property (cfg_rdata_out[8:7] == 2'h1 && $rose(timer_a_out)
        && $past(cfg_rdata_out[6:4]) != 3'h0 && $past(cfg_rdata_out[6:5]) != 2'h3
        |-> !cyclic_wake_out ##1 cyclic_wake_out) else $error("no wake pulse");
    chk_no_wake: assert property (cfg_rdata_out[8:7] == 2'h0 && $past(cfg_rdata_out[8:7], 2) == 2'h0
        && $stable(cfg_rdata_out[8:7]) |-> !cyclic_wake_out) else $error("wake pulse while disabled");
    chk_clear_fields: assert property (restart_mode_in && hs_clear_in[0] && hs_config_in[3:0] == 4'h2
        && !soft_reset_in |=> (cfg_rdata_out[6:0] & 7'h77) == 7'h00) else $error("timer A not cleared");
endmodule // cyclic_timers_checker
bind cyclic_sense_wake_timers cyclic_timers_checker u_chk (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
    .cfg_wr_in(cfg_wr_in), .cfg_wdata_in(cfg_wdata_in), .soft_reset_in(soft_reset_in),
    .restart_entry_in(restart_entry_in), .restart_mode_in(restart_mode_in), .hs_clear_in(hs_clear_in),
    .hs_config_in(hs_config_in), .cfg_rdata_out(cfg_rdata_out), .timer_a_out(timer_a_out),
    .high_side_switch_output_out(high_side_switch_output_out), .cyclic_wake_out(cyclic_wake_out));

// ===== dv/host_cfg_model.sv
/* Host side model: issues single-word writes to the timer register.
   Assumes the bench calls write_cfg from its main sequence. */
`timescale 1ns/1ps
module host_cfg_model (
    // Clock
    input wire sys_clk_in,
    // Register write side
    output logic cfg_wr_out,
    output logic [15:0] cfg_wdata_out
);
    initial begin
        cfg_wr_out = 1'b0;
        cfg_wdata_out = 16'h0000;
    end
    // Caller assigns the switch first, then writes the on-time
    task write_cfg(input logic [15:0] v);
        @(negedge sys_clk_in);
        cfg_wr_out = 1'b1;
        cfg_wdata_out = v;
        @(negedge sys_clk_in);
        cfg_wr_out = 1'b0;
        // Released data is not left looking valid
        cfg_wdata_out = ~v;
    endtask
endmodule // host_cfg_model

// ===== dv/cyclic_sense_wake_timers_tb.sv
/* Self-checking bench for the two cyclic timers.
   Assumes the host model for writes and the bound port checker. */
`timescale 1ns/1ps
module cyclic_sense_wake_timers_tb;
    logic clk = 1'b0, rstn = 1'b0, sres = 1'b0, rent = 1'b0, rmode = 1'b0, wpin = 1'b0;
    logic [3:0] hclr = 4'h0;
    logic [15:0] hcfg = 16'h0000, v;
    logic [2:0] fsel = 3'h2;
    logic [2:0] codes [3] = '{3'h0, 3'h6, 3'h7};
    logic [15:0] ons [2] = '{16'h09C4, 16'h1D4C};
    wire cfg_wr, ta, tb, cw, wv, wl;
    wire [15:0] cfg_wd, rd;
    wire [3:0] hs;
    int err_count = 0, total_checks = 0, n;
    initial forever #20 clk = ~clk;
    host_cfg_model u_host (.sys_clk_in(clk), .cfg_wr_out(cfg_wr), .cfg_wdata_out(cfg_wd));
    cyclic_sense_wake_timers u_dut (.sys_clk_in(clk), .rstn_in(rstn), .cfg_wr_in(cfg_wr),
        .cfg_wdata_in(cfg_wd), .cfg_rdata_out(rd), .soft_reset_in(sres), .restart_entry_in(rent),
        .restart_mode_in(rmode), .hs_clear_in(hclr), .hs_config_in(hcfg),
        .wake_input_filter_select_in(fsel), .wake_pin_in(wpin), .timer_a_out(ta), .timer_b_out(tb),
        .high_side_switch_output_out(hs), .cyclic_wake_out(cw), .wake_sample_valid_out(wv),
        .wake_level_out(wl));
    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function logic [15:0] visible(input logic [15:0] w);
        return w & 16'hEFF7;
    endfunction
    task end_of_test;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Bounded wait for a level on timer A, counting cycles spent
    task wait_ta(input logic lvl, input int lim);
        n = 0;
        while (ta !== lvl) begin
            @(negedge clk);
            n++;
            if (n > lim) begin
                err_count++;
                end_of_test;
            end
        end
    endtask
    // Same bounded wait on timer B
    task wait_tb(input logic lvl, input int lim);
        n = 0;
        while (tb !== lvl) begin
            @(negedge clk);
            n++;
            if (n > lim) begin
                err_count++;
                end_of_test;
            end
        end
    endtask
    initial begin
        void'($urandom(32'hA2F2760A));
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        chk("reset", rd, 16'h0000);
        for (int i = 0; i < 20; i++) begin
            v = $urandom;
            wpin = v[0];
            u_host.write_cfg(v);
            chk("echo", rd, visible(v));
        end
        u_host.write_cfg(16'hFFFF);
        chk("mask", rd, 16'hEFF7);
        @(negedge clk) rent = 1'b1;
        @(negedge clk) rent = 1'b0;
        chk("restart", rd, 16'h0000);
        u_host.write_cfg(16'h1234);
        @(negedge clk) sres = 1'b1;
        @(negedge clk) sres = 1'b0;
        chk("soft", rd, 16'h0000);
        foreach (codes[i]) begin
            u_host.write_cfg({codes[i], 6'h00, codes[i], 4'h0});
            repeat (2) @(negedge clk);
            chk("a_stop", {15'h0000, ta}, {15'h0000, codes[i][2:1] == 2'h3});
            chk("b_stop", {15'h0000, tb}, {15'h0000, codes[i][2:1] == 2'h3});
        end
        hcfg = 16'h0032;
        foreach (ons[i]) begin
            // Pin level flips each pass so a stuck filter output shows
            wpin = ~wpin;
            u_host.write_cfg(16'h0000);
            u_host.write_cfg({9'h001, i[2:0] + 3'h1, 4'h0});
            wait_ta(1'b1, 30);
            @(negedge clk);
            chk("hs_a", {15'h0000, hs[0]}, 16'h0001);
            wait_ta(1'b0, 8000);
            chk("on_time", n[15:0] + 16'h0001, ons[i]);
            @(negedge clk);
            chk("wake_smp", {14'h0000, wv, wl}, {14'h0000, 1'b1, wpin});
        end
        // Timer B as switch source and wake source at once
        fsel = 3'h3;
        u_host.write_cfg(16'h2100);
        wait_tb(1'b1, 30);
        @(negedge clk);
        chk("hs_b_wake", {14'h0000, hs[1], cw}, 16'h0003);
        @(negedge clk);
        chk("wake_once", {15'h0000, cw}, 16'h0000);
        // Pin moves about 8 us before the on-time ends: level must not update
        repeat (2300) @(negedge clk);
        wpin = ~wpin;
        wait_tb(1'b0, 300);
        @(negedge clk);
        chk("wake_unstable", {14'h0000, wv, wl}, {14'h0000, 1'b1, ~wpin});
        @(negedge clk);
        chk("smp_once", {15'h0000, wv}, 16'h0000);
        u_host.write_cfg(16'h2A95);
        @(negedge clk) hclr = 4'h1;
        @(negedge clk) hclr = 4'h0;
        chk("no_mode", rd, 16'h2A95);
        @(negedge clk);
        rmode = 1'b1;
        hclr = 4'h1;
        @(negedge clk) hclr = 4'h2;
        @(negedge clk) hclr = 4'h0;
        rmode = 1'b0;
        chk("sw_clear", rd, 16'h0080);
        // Reset in mid-run while timer A is high
        u_host.write_cfg(16'h0010);
        wait_ta(1'b1, 30);
        rstn = 1'b0;
        @(negedge clk);
        chk("por", rd, 16'h0000);
        rstn = 1'b1;
        repeat (2) @(negedge clk);
        chk("por_rd", rd, 16'h0000);
        chk("por_out", {7'h00, hs, ta, tb, cw, wv, wl}, 16'h0000);
        end_of_test;
    end
endmodule // cyclic_sense_wake_timers_tb
